/* File: hw/ext_irq_flag_clock_source_reg.sv */
// Contract
// - Falling edges on pins 5,3 set bits 7,5
// - Rising edges on pins 4,2 set bits 6,4
// - Edge flags clear only by software zero or any reset
// - Software-set flag requests interrupt like edge
// - Select one picks crystal, zero picks ring
// - Setting select needs warm-up done, crystal on
// - Select reads inverse of ring status while running
// - Power-on reset sets select; others keep
// - Ring status shows active clock source
// - Power-on reset clears ring status, resume
// - Resume select zero holds until warm-up
// - Resume select one runs ring, then switches
// - Band-gap bit timed-access only, resets zero
// - Band-gap off in Stop unless bit set
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
`default_nettype none

module ext_irq_flag_clock_source_reg
  import ext_irq_pkg::*;
#(
  parameter bit HAS_RING_OSC = 1'b1
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  input  wire logic       i_por,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic       i_edge_pin_5,
  input  wire logic       i_edge_pin_4,
  input  wire logic       i_edge_pin_3,
  input  wire logic       i_edge_pin_2,
  input  wire logic       i_crystal_warm_status,
  input  wire logic       i_crystal_off_control,
  input  wire logic       i_timed_access_open,
  input  wire logic       i_stop_mode,
  input  wire logic       i_stop_exit,
  output logic      [3:0] o_irq_req,
  output logic            o_clock_source_select,
  output logic            o_ring_mode_status,
  output logic            o_hold_operation,
  output logic            o_bandgap_enable
);

  import ext_irq_pkg::*;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic [3:0] edge_hit;

  edge_flag_detect #(.KIND(EDGE_RISING)) u_edge_2 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_pin     (i_edge_pin_2),
    .o_edge    (edge_hit[0])
  );
  edge_flag_detect #(.KIND(EDGE_FALLING)) u_edge_3 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_pin     (i_edge_pin_3),
    .o_edge    (edge_hit[1])
  );
  edge_flag_detect #(.KIND(EDGE_RISING)) u_edge_4 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_pin     (i_edge_pin_4),
    .o_edge    (edge_hit[2])
  );
  edge_flag_detect #(.KIND(EDGE_FALLING)) u_edge_5 (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_pin     (i_edge_pin_5),
    .o_edge    (edge_hit[3])
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic       clk_sel_r;
  logic       clk_sel_nxt;
  logic       ring_mode_r;
  logic       ring_mode_nxt;
  logic       resume_sel_r;
  logic       resume_sel_nxt;
  logic       bgs_r;
  logic       bgs_nxt;
  clk_state_t state_r;
  clk_state_t state_nxt;
  logic [7:0] rdata_nxt;
  logic       wr_hit;
  logic       sel_allowed;
  logic       clk_sel_rd;
  logic       ring_rd;

  assign wr_hit      = i_sfr_wr & (i_sfr_addr == `EXT_EDGE_FLAGS_CLOCK_SELECT_ADDR);
  assign sel_allowed = i_crystal_warm_status & ~i_crystal_off_control;
  assign clk_sel_rd  = HAS_RING_OSC ? clk_sel_r : 1'b1;
  assign ring_rd     = HAS_RING_OSC ? ring_mode_r : 1'b0;

  always_comb
  begin
    // Software value first, edges OR'ed after so a set wins a clear
    flags_nxt = flags_r;
    if (wr_hit)
      flags_nxt = i_sfr_wdata[`EDGE_FLAG_5_BIT:`EDGE_FLAG_2_BIT];
    flags_nxt = flags_nxt | edge_hit;

    clk_sel_nxt    = clk_sel_r;
    resume_sel_nxt = resume_sel_r;
    bgs_nxt        = bgs_r;
    if (wr_hit)
    begin
      // Clearing always allowed, setting only when crystal is ready
      if (!i_sfr_wdata[`CLOCK_SOURCE_SELECT_BIT] || sel_allowed)
        clk_sel_nxt = i_sfr_wdata[`CLOCK_SOURCE_SELECT_BIT];
      resume_sel_nxt = i_sfr_wdata[`RING_RESUME_SELECT_BIT];
      if (i_timed_access_open)
        bgs_nxt = i_sfr_wdata[`BANDGAP_STOP_ENABLE_BIT];
    end

    state_nxt = state_r;
    case (state_r)
      CLK_RUN_XTAL, CLK_RUN_RING:
      begin
        if (i_stop_mode)
          state_nxt = CLK_STOPPED;
        else
          state_nxt = clk_sel_nxt ? CLK_RUN_XTAL : CLK_RUN_RING;
      end
      CLK_STOPPED:
      begin
        if (i_stop_exit)
          state_nxt = resume_sel_r ? CLK_WARM_RING : CLK_WARM_HOLD;
      end
      CLK_WARM_HOLD, CLK_WARM_RING:
      begin
        if (i_crystal_warm_status)
          state_nxt = clk_sel_nxt ? CLK_RUN_XTAL : CLK_RUN_RING;
      end
      default:
        state_nxt = CLK_RUN_XTAL;
    endcase

    // Stop and held warm-up keep the last reported source
    case (state_nxt)
      CLK_RUN_RING, CLK_WARM_RING: ring_mode_nxt = 1'b1;
      CLK_RUN_XTAL:                ring_mode_nxt = 1'b0;
      default:                     ring_mode_nxt = ring_mode_r;
    endcase

    rdata_nxt = `READ_DATA_IDLE;
    if (i_sfr_rd && (i_sfr_addr == `EXT_EDGE_FLAGS_CLOCK_SELECT_ADDR))
      rdata_nxt = {flags_r, clk_sel_rd, ring_rd, resume_sel_r, bgs_r};
  end

  // Only a power-on reset touches the clock controls; a watchdog or
  // pin reset must not upset a running oscillator choice
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      flags_r     <= `EDGE_FLAGS_RST;
      bgs_r       <= `BANDGAP_STOP_ENABLE_RST;
      o_sfr_rdata <= `READ_DATA_IDLE;
      if (i_por)
      begin
        clk_sel_r    <= `CLOCK_SOURCE_SELECT_POR;
        ring_mode_r  <= `RING_MODE_STATUS_POR;
        resume_sel_r <= `RING_RESUME_SELECT_POR;
        state_r      <= CLK_RUN_XTAL;
      end
    end
    else if (i_ce)
    begin
      flags_r      <= flags_nxt;
      bgs_r        <= bgs_nxt;
      o_sfr_rdata  <= rdata_nxt;
      clk_sel_r    <= clk_sel_nxt;
      ring_mode_r  <= ring_mode_nxt;
      resume_sel_r <= resume_sel_nxt;
      state_r      <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_irq_req             = flags_r;
  assign o_clock_source_select = clk_sel_rd;
  assign o_ring_mode_status    = ring_rd;
  assign o_hold_operation      = (state_r == CLK_WARM_HOLD);
  assign o_bandgap_enable      = ~i_stop_mode | bgs_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic por_done_r;

  always_ff @(posedge i_ref_clk)
  begin
    por_done_r <= i_srst & i_por;
  end

  sequence s_stop_exit_hold;
    i_ce && state_r == CLK_STOPPED && i_stop_exit && !resume_sel_r;
  endsequence

  sequence s_stop_exit_ring;
    i_ce && state_r == CLK_STOPPED && i_stop_exit && resume_sel_r;
  endsequence

  sequence s_hold_warm_done;
    o_hold_operation && i_ce && i_crystal_warm_status;
  endsequence

  AST_FALL_EDGE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_ce && (edge_hit[3] || edge_hit[1]) |=>
      (flags_r[3] || !$past(edge_hit[3])) && (flags_r[1] || !$past(edge_hit[1])))
    else $error("Falling edge did not set its flag");

  AST_RISE_EDGE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_ce && (edge_hit[2] || edge_hit[0]) |=>
      (flags_r[2] || !$past(edge_hit[2])) && (flags_r[0] || !$past(edge_hit[0])))
    else $error("Rising edge did not set its flag");

  AST_NO_SELF_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !wr_hit |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("Edge flag cleared without a software write");

  AST_SW_SET_REQ: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_ce && wr_hit |=> (o_irq_req & $past(i_sfr_wdata[7:4])) == $past(i_sfr_wdata[7:4]))
    else $error("Software-set flag gave no request");

  AST_SEL_GATE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_ce && wr_hit && i_sfr_wdata[3] && !sel_allowed && !clk_sel_r |=> !clk_sel_r)
    else $error("Select set while crystal not ready");

  AST_SEL_INVERSE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    HAS_RING_OSC && (state_r == CLK_RUN_XTAL || state_r == CLK_RUN_RING) |->
      clk_sel_rd == !ring_rd)
    else $error("Select does not mirror ring status");

  AST_POR_VALUES: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    por_done_r |-> clk_sel_r && !ring_mode_r && !resume_sel_r && !bgs_r)
    else $error("Power-on values wrong");

  AST_HOLD_ENTER: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_stop_exit_hold |=> o_hold_operation)
    else $error("Hold did not start on crystal resume");

  AST_HOLD_KEEP: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_hold_operation && !(i_ce && i_crystal_warm_status) |=> o_hold_operation)
    else $error("Hold ended before warm-up");

  AST_HOLD_RELEASE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_hold_warm_done |=> !o_hold_operation)
    else $error("Hold did not end after warm-up");

  AST_RING_START: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_stop_exit_ring |=> ring_mode_r && !o_hold_operation)
    else $error("Ring resume did not start at once");

  AST_RING_RESUME: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_ce && state_r == CLK_WARM_RING && i_crystal_warm_status |=>
      (state_r == CLK_RUN_XTAL) == $past(clk_sel_nxt) && ring_mode_r == !$past(clk_sel_nxt))
    else $error("Ring resume did not switch to selected source");

  AST_BGS_LOCKED: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    i_ce && wr_hit && !i_timed_access_open |=> $stable(bgs_r))
    else $error("Band-gap bit changed without unlock");

endmodule : ext_irq_flag_clock_source_reg

`default_nettype wire

/* File: hw/ext_irq_regs.svh */
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH

// ----------------------------------------------------------------
// Register location and field positions
// ----------------------------------------------------------------
`define EXT_EDGE_FLAGS_CLOCK_SELECT_ADDR 8'h91
`define EDGE_FLAG_5_BIT                  7
`define EDGE_FLAG_4_BIT                  6
`define EDGE_FLAG_3_BIT                  5
`define EDGE_FLAG_2_BIT                  4
`define CLOCK_SOURCE_SELECT_BIT          3
`define RING_MODE_STATUS_BIT             2
`define RING_RESUME_SELECT_BIT           1
`define BANDGAP_STOP_ENABLE_BIT          0

// ----------------------------------------------------------------
// Values after reset
// ----------------------------------------------------------------
`define EDGE_FLAGS_RST                   4'h0
`define CLOCK_SOURCE_SELECT_POR          1'b1
`define RING_MODE_STATUS_POR             1'b0
`define RING_RESUME_SELECT_POR           1'b0
`define BANDGAP_STOP_ENABLE_RST          1'b0
`define READ_DATA_IDLE                   8'h00

`endif

/* File: hw/ext_irq_pkg.sv */
package ext_irq_pkg;

  // ----------------------------------------------------------------
  // Clock source sequencing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLK_RUN_XTAL  = 3'b000,
    CLK_RUN_RING  = 3'b001,
    CLK_STOPPED   = 3'b010,
    CLK_WARM_HOLD = 3'b011,
    CLK_WARM_RING = 3'b100
  } clk_state_t;

  typedef enum logic {
    EDGE_RISING  = 1'b0,
    EDGE_FALLING = 1'b1
  } edge_kind_t;

endpackage : ext_irq_pkg

/* File: hw/edge_flag_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module edge_flag_detect
  import ext_irq_pkg::*;
#(
  parameter edge_kind_t KIND = EDGE_RISING
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_pin,
  output logic      o_edge
);

  logic prev_r;
  logic prev_nxt;

  // Idle level as reset value so a pin resting at idle makes no edge
  always_comb
  begin
    prev_nxt = i_pin;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      prev_r <= (KIND == EDGE_FALLING);
    else if (i_ce)
      prev_r <= prev_nxt;
  end

  assign o_edge = (KIND == EDGE_FALLING) ? (prev_r & ~i_pin) : (~prev_r & i_pin);

endmodule : edge_flag_detect

`default_nettype wire

/* File: verif/sfr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Processor core seen from the SFR bus
// ----------------------------------------
module sfr_core_model
(
  input  wire logic       i_ref_clk,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata,
  output logic            o_unlock,
  input  wire logic [7:0] i_rdata
);
  initial
  begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
    o_unlock = 1'b0;
  end

  // Idle edge after each access keeps strobes from toggling twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ul);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    o_unlock = ul;
    @(posedge i_ref_clk);
    #1;
    o_wr = 1'b0;
    o_unlock = 1'b0;
    o_wdata = ~d;
    o_addr = ~a;
    @(posedge i_ref_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
    @(posedge i_ref_clk);
    #1;
  endtask : rd
endmodule : sfr_core_model

`default_nettype wire

/* File: verif/test_ext_irq_flag_clock_source_reg.sv */
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
`default_nettype none

module test_ext_irq_flag_clock_source_reg;
  localparam logic [7:0] REG_ADDR   = `EXT_EDGE_FLAGS_CLOCK_SELECT_ADDR;
  localparam logic [7:0] OTHER_ADDR = 8'h90;
  logic       clk, srst, por, ce, warm, xoff, stop, sexit, p5, p4, p3, p2;
  logic [7:0] addr, wdata, rdata, rv;
  logic       wr, rd, unlock, sel, ring, hold, bg, sel_nr;
  logic [3:0] irq;
  int         n_errors, tests_run;

  sfr_core_model core (.i_ref_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .o_unlock(unlock), .i_rdata(rdata));

  ext_irq_flag_clock_source_reg dut (.i_ref_clk(clk), .i_srst(srst), .i_por(por),
    .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_edge_pin_5(p5), .i_edge_pin_4(p4), .i_edge_pin_3(p3),
    .i_edge_pin_2(p2), .i_crystal_warm_status(warm), .i_crystal_off_control(xoff),
    .i_timed_access_open(unlock), .i_stop_mode(stop), .i_stop_exit(sexit),
    .o_irq_req(irq), .o_clock_source_select(sel), .o_ring_mode_status(ring),
    .o_hold_operation(hold), .o_bandgap_enable(bg));

  // Variant without a ring oscillator, fed the same stimulus
  ext_irq_flag_clock_source_reg #(.HAS_RING_OSC(1'b0)) dut_no_ring (.i_ref_clk(clk),
    .i_srst(srst), .i_por(por), .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(), .i_edge_pin_5(p5),
    .i_edge_pin_4(p4), .i_edge_pin_3(p3), .i_edge_pin_2(p2),
    .i_crystal_warm_status(warm), .i_crystal_off_control(xoff),
    .i_timed_access_open(unlock), .i_stop_mode(stop), .i_stop_exit(sexit),
    .o_irq_req(), .o_clock_source_select(sel_nr), .o_ring_mode_status(),
    .o_hold_operation(), .o_bandgap_enable());

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] exp);
    core.rd(REG_ADDR, rv);
    check(rv, exp);
  endtask : rdchk

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  task automatic t_edges;
    p5 = 1'b0;
    tick(1);
    check({4'h0, irq}, 8'h08);
    p4 = 1'b1;
    tick(1);
    check({4'h0, irq}, 8'h0C);
    p3 = 1'b0;
    tick(1);
    check({4'h0, irq}, 8'h0E);
    p2 = 1'b1;
    tick(5);
    check({4'h0, irq}, 8'h0F);
    rdchk(8'hF8);
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({4'h0, irq}, 8'h00);
    // Opposite edges must not set anything
    p5 = 1'b1;
    p4 = 1'b0;
    p3 = 1'b1;
    p2 = 1'b0;
    tick(3);
    check({4'h0, irq}, 8'h00);
    core.wr(REG_ADDR, 8'hA8, 1'b0);
    check({4'h0, irq}, 8'h0A);
    // Other addresses neither write nor read the register
    core.wr(OTHER_ADDR, 8'h08, 1'b0);
    check({4'h0, irq}, 8'h0A);
    core.rd(OTHER_ADDR, rv);
    check(rv, 8'h00);
    // Edge in the cycle of a clearing write keeps its flag
    p4 = 1'b1;
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({4'h0, irq}, 8'h04);
    p4 = 1'b0;
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({4'h0, irq}, 8'h00);
    // Low clock enable freezes flags and pin history
    ce = 1'b0;
    p5 = 1'b0;
    tick(2);
    check({4'h0, irq}, 8'h00);
    ce = 1'b1;
    tick(1);
    check({4'h0, irq}, 8'h08);
    p5 = 1'b1;
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({4'h0, irq}, 8'h00);
    $display("test edges done");
  endtask : t_edges

  task automatic t_select;
    core.wr(REG_ADDR, 8'h00, 1'b0);
    check({7'h00, sel}, 8'h00);
    check({7'h00, ring}, 8'h01);
    check({7'h00, sel_nr}, 8'h01);
    warm = 1'b0;
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({7'h00, sel}, 8'h00);
    warm = 1'b1;
    xoff = 1'b1; // on ring already
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({7'h00, sel}, 8'h00);
    xoff = 1'b0;
    core.wr(REG_ADDR, 8'h08, 1'b0);
    check({7'h00, sel}, 8'h01);
    rdchk(8'h08);
    core.wr(REG_ADDR, 8'h09, 1'b0);
    rdchk(8'h08);
    core.wr(REG_ADDR, 8'h09, 1'b1);
    rdchk(8'h09);
    $display("test select done");
  endtask : t_select

  task automatic stop_run(input logic [7:0] cfg, input logic bgx, input logic hx,
                          input logic rx, input logic fx);
    core.wr(REG_ADDR, cfg, 1'b1);
    warm = 1'b0;
    stop = 1'b1;
    #1 check({7'h00, bg}, {7'h00, bgx});
    @(posedge clk);
    #1 stop = 1'b0;
    tick(1);
    check({7'h00, bg}, 8'h01);
    sexit = 1'b1;
    tick(1);
    sexit = 1'b0;
    check({7'h00, hold}, {7'h00, hx});
    check({7'h00, ring}, {7'h00, rx});
    tick(3);
    check({7'h00, hold}, {7'h00, hx});
    warm = 1'b1;
    tick(1);
    check({7'h00, hold}, 8'h00);
    check({7'h00, ring}, {7'h00, fx});
    $display("test stop done");
  endtask : stop_run

  task automatic t_reset;
    core.wr(REG_ADDR, 8'hF2, 1'b0);
    por = 1'b0;
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    check({7'h00, sel}, 8'h00);
    check({7'h00, ring}, 8'h01);
    rdchk(8'h06);
    por = 1'b1;
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    rdchk(8'h08);
    check({7'h00, ring}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    n_errors++;
    test_done;
  end

  initial
  begin
    {srst, por, warm, xoff, stop, sexit} = 6'b111000;
    {p5, p4, p3, p2} = 4'b1010;
    ce = 1'b1;
    n_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    rdchk(8'h08);
    t_edges;
    t_select;
    stop_run(8'h09, 1'b1, 1'b1, 1'b0, 1'b0);
    stop_run(8'h0A, 1'b0, 1'b0, 1'b1, 1'b0);
    stop_run(8'h02, 1'b0, 1'b0, 1'b1, 1'b1);
    t_reset;
    test_done;
  end
endmodule : test_ext_irq_flag_clock_source_reg

`default_nettype wire
